// ==== verilog/rdt_map.svh ====
// Purpose: Offsets, field positions, reset values and counts of the radio deviation block.
// Assumes: APB word addressing, byte address is four times the register index.
// Notes:   Definitions only.
`ifndef RDT_MAP_SVH
`define RDT_MAP_SVH

`define RDT_DEV_IDX        20'h0_DF11
`define RDT_SM2_IDX        20'h0_DF12
`define RDT_CTRL_IDX       20'h0_DF20
`define RDT_EV0_IDX        20'h0_DF21
`define RDT_STAT_IDX       20'h0_DF22

`define RDT_DEV_RST        8'h47
`define RDT_SM2_RST        8'h07
`define RDT_CTRL_RST       8'h00
`define RDT_EV0_RST        16'h0000

`define RDT_DEV_WMASK      8'h77
`define RDT_SM2_WMASK      8'h1F
`define RDT_CTRL_WMASK     8'h3F

`define RDT_DEV_BASE       4'h8
`define RDT_TIME_OFF       3'h7
`define RDT_CS_SYMBOLS     4'h8
`define RDT_TICK_SHIFT     3'h6

`endif

// ==== verilog/rdt_pkg.sv ====
// Purpose: Types shared by the radio deviation and RX timeout block.
// Assumes: Field layout as given in rdt_map.svh.
// Notes:   Nothing is imported; use rdt_pkg::name.
package rdt_pkg;

  typedef enum logic [1:0] {
    RDT_MOD_FSK2 = 2'b00,
    RDT_MOD_GFSK = 2'b01,
    RDT_MOD_ASK  = 2'b10,
    RDT_MOD_MSK  = 2'b11
  } rdt_mod_t;

  typedef enum logic [1:0] {
    RDT_ST_IDLE   = 2'b00,
    RDT_ST_SEARCH = 2'b01,
    RDT_ST_KEEP   = 2'b10,
    RDT_ST_ENDED  = 2'b11
  } rdt_state_t;

  typedef struct packed {
    logic       unused7;
    logic [2:0] dev_exp;
    logic       unused3;
    logic [2:0] dev_mant;
  } rdt_dev_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       rx_carrier_sense_stop;
    logic       rx_timeout_quality_keep;
    logic [2:0] rx_time;
  } rdt_sm2_t;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] wake_timer_resolution;
    logic       tx_mode;
    logic       rx_mode;
    rdt_mod_t   mod_fmt;
  } rdt_ctrl_t;

  typedef struct packed {
    logic       carrier_sense;
    logic       sync_found;
    logic       quality_reached;
    logic       sym_tick;
    logic       tx_bit;
  } rdt_radio_in_t;

  typedef struct packed {
    logic        timeout_seen;
    logic        cs_seen;
    logic        quality_seen;
    logic        sync_seen;
    rdt_state_t  state;
  } rdt_status_t;

endpackage

// ==== verilog/rdt_rx_timer.sv ====
// Purpose: Sync-search timer counting fine wake ticks up to a loaded limit.
// Assumes: tick_64 pulses 64 times per unit of the selected timeout factor.
// Notes:   Setting 111 of the timeout field never expires.
`timescale 1ns/100ps
`include "rdt_map.svh"

module rdt_rx_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        tick_64,
  input  wire logic [15:0] wake_event_zero_period,
  input  wire logic [2:0]  rx_time,
  output logic             expired
);

  logic [21:0] limit_q;
  logic [21:0] limit_d;
  logic [21:0] cnt_q;
  logic [21:0] cnt_d;
  logic        run_q;
  logic        run_d;
  logic        exp_q;
  logic        exp_d;

  always_comb begin
    limit_d = limit_q;
    cnt_d   = cnt_q;
    run_d   = run_q;
    exp_d   = 1'b0;
    if (start) begin
      // Each step of the field halves the limit.
      limit_d = 22'({6'h00, wake_event_zero_period} << (`RDT_TICK_SHIFT - rx_time));
      cnt_d   = 22'h00_0000;
      run_d   = (rx_time != `RDT_TIME_OFF) && (wake_event_zero_period != 16'h0000);
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q && tick_64) begin
      cnt_d = cnt_q + 22'h00_0001;
      if (cnt_d >= limit_q) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      limit_q <= 22'h00_0000;
      cnt_q   <= 22'h00_0000;
      run_q   <= 1'b0;
      exp_q   <= 1'b0;
    end else begin
      limit_q <= limit_d;
      cnt_q   <= cnt_d;
      run_q   <= run_d;
      exp_q   <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule

// ==== verilog/rdt_top.sv ====
// Purpose: Deviation and RX sync-search timeout registers with their radio behaviour.
// Assumes: Radio status inputs come from logic on ref_clk; APB slave, zero wait states.
// Notes:   Deviation is expressed in units of fref divided by 2^17.
// Behaviour
// - FSK/GFSK TX offset minus/plus deviation per bit.
// - MSK: mantissa sets phase-change fraction, direction.
// - Deviation ignored for ASK TX, MSK/ASK RX.
// - FSK/GFSK RX uses deviation as expected value.
// - Carrier-sense stop; ASK times out after 8 symbols.
// - On expiry stay if sync, or quality option.
// - Sync search bounded by timer; field resets 111.
// - Timeout scales wake period by factor C.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "rdt_map.svh"

module rdt_top (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rx_active,
  input  wire logic                  tick_64,
  input  wire rdt_pkg::rdt_radio_in_t radio_in,
  output logic signed [11:0]         tx_freq_offset,
  output logic [10:0]                rx_expected_dev,
  output logic [3:0]                 msk_phase_eighths,
  output logic                       msk_phase_up,
  output logic                       rx_timeout
);

  rdt_pkg::rdt_dev_t    dev_q;
  rdt_pkg::rdt_dev_t    dev_d;
  rdt_pkg::rdt_sm2_t    sm2_q;
  rdt_pkg::rdt_sm2_t    sm2_d;
  rdt_pkg::rdt_ctrl_t   ctrl_q;
  rdt_pkg::rdt_ctrl_t   ctrl_d;
  logic [15:0]          ev0_q;
  logic [15:0]          ev0_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic                 err_q;
  logic                 err_d;
  rdt_pkg::rdt_status_t st_q;
  rdt_pkg::rdt_status_t st_d;
  logic [3:0]           sym_q;
  logic [3:0]           sym_d;
  logic                 rx_prev_q;
  logic                 to_q;
  logic                 to_d;
  logic signed [11:0]   txo_q;
  logic signed [11:0]   txo_d;
  logic [10:0]          rxd_q;
  logic [10:0]          rxd_d;
  logic [3:0]           msk_q;
  logic [3:0]           msk_d;
  logic                 mup_q;
  logic                 mup_d;
  logic [29:0]          idx;
  logic                 setup;
  logic                 access;
  logic                 hit;
  logic [10:0]          dev_units;
  logic                 rx_start;
  logic                 timer_exp;
  logic                 is_fsk;

  assign idx    = paddr[31:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = (idx == 30'(`RDT_DEV_IDX)) || (idx == 30'(`RDT_SM2_IDX))
               || (idx == 30'(`RDT_CTRL_IDX)) || (idx == 30'(`RDT_EV0_IDX))
               || (idx == 30'(`RDT_STAT_IDX));
  assign is_fsk = (ctrl_q.mod_fmt == rdt_pkg::RDT_MOD_FSK2)
               || (ctrl_q.mod_fmt == rdt_pkg::RDT_MOD_GFSK);
  assign dev_units = 11'({7'h00, `RDT_DEV_BASE + {1'b0, dev_q.dev_mant}} << dev_q.dev_exp);
  assign rx_start  = rx_active && !rx_prev_q;

  // Register file and APB answer.
  always_comb begin
    dev_d   = dev_q;
    sm2_d   = sm2_q;
    ctrl_d  = ctrl_q;
    ev0_d   = ev0_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d   = !hit;
      rdata_d = 32'h0000_0000;
      case (idx)
        30'(`RDT_DEV_IDX):  rdata_d = {24'h00_0000, dev_q};
        30'(`RDT_SM2_IDX):  rdata_d = {24'h00_0000, sm2_q};
        30'(`RDT_CTRL_IDX): rdata_d = {24'h00_0000, ctrl_q};
        30'(`RDT_EV0_IDX):  rdata_d = {16'h0000, ev0_q};
        30'(`RDT_STAT_IDX): rdata_d = {26'h000_0000, st_q};
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
    if (access && pwrite) begin
      case (idx)
        30'(`RDT_DEV_IDX):  dev_d  = pwdata[7:0] & `RDT_DEV_WMASK;
        30'(`RDT_SM2_IDX):  sm2_d  = pwdata[7:0] & `RDT_SM2_WMASK;
        30'(`RDT_CTRL_IDX): ctrl_d = pwdata[7:0] & `RDT_CTRL_WMASK;
        30'(`RDT_EV0_IDX):  ev0_d  = pwdata[15:0];
        default:            ev0_d  = ev0_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dev_q   <= `RDT_DEV_RST;
      sm2_q   <= `RDT_SM2_RST;
      ctrl_q  <= `RDT_CTRL_RST;
      ev0_q   <= `RDT_EV0_RST;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      dev_q   <= dev_d;
      sm2_q   <= sm2_d;
      ctrl_q  <= ctrl_d;
      ev0_q   <= ev0_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = access;
  assign pslverr = access && err_q;

  // Modulator and demodulator deviation outputs.
  always_comb begin
    txo_d = 12'sh000;
    rxd_d = 11'h000;
    msk_d = 4'h0;
    mup_d = 1'b0;
    if (ctrl_q.tx_mode && is_fsk) begin
      txo_d = radio_in.tx_bit ? $signed({1'b0, dev_units})
                              : -$signed({1'b0, dev_units});
    end
    if (ctrl_q.tx_mode && (ctrl_q.mod_fmt == rdt_pkg::RDT_MOD_MSK)) begin
      msk_d = 4'h1 + {1'b0, dev_q.dev_mant};
      mup_d = !radio_in.tx_bit;
    end
    if (ctrl_q.rx_mode && !ctrl_q.tx_mode && is_fsk) begin
      rxd_d = dev_units;
    end
  end // ASK TX and MSK/ASK RX leave all outputs at zero.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txo_q <= 12'sh000;
      rxd_q <= 11'h000;
      msk_q <= 4'h0;
      mup_q <= 1'b0;
    end else begin
      txo_q <= txo_d;
      rxd_q <= rxd_d;
      msk_q <= msk_d;
      mup_q <= mup_d;
    end
  end

  assign tx_freq_offset    = txo_q;
  assign rx_expected_dev   = rxd_q;
  assign msk_phase_eighths = msk_q;
  assign msk_phase_up      = mup_q;

  // Sync-search supervision.
  rdt_rx_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (rx_start),
    .stop    (!rx_active),
    .tick_64 (tick_64),
    .wake_event_zero_period (ev0_q),
    .rx_time (sm2_q.rx_time),
    .expired (timer_exp)
  );

  always_comb begin
    st_d  = st_q;
    sym_d = sym_q;
    to_d  = 1'b0;
    case (st_q.state)
      rdt_pkg::RDT_ST_IDLE: begin
        if (rx_start) begin
          st_d  = '0;
          sym_d = 4'h0;
          st_d.state = rdt_pkg::RDT_ST_SEARCH;
        end
      end
      rdt_pkg::RDT_ST_SEARCH: begin
        st_d.sync_seen = st_q.sync_seen | radio_in.sync_found;
        st_d.quality_seen = st_q.quality_seen | radio_in.quality_reached;
        st_d.cs_seen   = st_q.cs_seen | radio_in.carrier_sense;
        if (radio_in.sym_tick && (sym_q != `RDT_CS_SYMBOLS)) begin
          sym_d = sym_q + 4'h1;
        end
        if (radio_in.sync_found) begin
          st_d.state = rdt_pkg::RDT_ST_KEEP;
        end else if (sm2_q.rx_carrier_sense_stop && (ctrl_q.mod_fmt == rdt_pkg::RDT_MOD_ASK)
                     && !st_d.cs_seen && (sym_d == `RDT_CS_SYMBOLS)) begin
          to_d = 1'b1;
        end else if (sm2_q.rx_carrier_sense_stop && (ctrl_q.mod_fmt != rdt_pkg::RDT_MOD_ASK)
                     && st_q.cs_seen && !radio_in.carrier_sense) begin
          to_d = 1'b1;
        end else if (timer_exp) begin
          if (!(sm2_q.rx_timeout_quality_keep && st_d.quality_seen)) begin
            to_d = 1'b1;
          end else begin
            st_d.state = rdt_pkg::RDT_ST_KEEP;
          end
        end
        if (to_d) begin
          st_d.timeout_seen = 1'b1;
          st_d.state = rdt_pkg::RDT_ST_ENDED;
        end
      end
      rdt_pkg::RDT_ST_KEEP: begin
        st_d.sync_seen = st_q.sync_seen | radio_in.sync_found;
      end
      rdt_pkg::RDT_ST_ENDED: begin
        st_d.state = st_q.state;
      end
      default: begin
        st_d.state = rdt_pkg::RDT_ST_IDLE;
      end
    endcase
    if (!rx_active && (st_q.state != rdt_pkg::RDT_ST_IDLE)) begin
      // Leaving RX never reports a timeout.
      to_d              = 1'b0;
      st_d.timeout_seen = st_q.timeout_seen;
      st_d.state        = rdt_pkg::RDT_ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q      <= '0;
      sym_q     <= 4'h0;
      to_q      <= 1'b0;
      rx_prev_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      sym_q     <= sym_d;
      to_q      <= to_d;
      rx_prev_q <= rx_active;
    end
  end

  assign rx_timeout = to_q;

endmodule

// ==== verif/rdt_top_monitor.sv ====
// Purpose: Port checks of rdt_top.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to rdt_top below.
`timescale 1ns/100ps
module rdt_top_monitor (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   rx_active,
  input wire rdt_pkg::rdt_radio_in_t radio_in,
  input wire logic signed [11:0]     tx_freq_offset,
  input wire logic [10:0]            rx_expected_dev,
  input wire logic [3:0]             msk_phase_eighths,
  input wire logic                   msk_phase_up,
  input wire logic                   rx_timeout
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_idle; !psel |-> !pready && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("answer while idle");
  property p_pulse; rx_timeout |=> !rx_timeout; endproperty
  a_pulse: assert property (p_pulse) else $error("timeout too long");
  property p_cause; rx_timeout |-> $past(rx_active); endproperty
  a_cause: assert property (p_cause) else $error("timeout outside rx");
  property p_range; tx_freq_offset <= 12'sd1920 && tx_freq_offset >= -12'sd1920; endproperty
  a_range: assert property (p_range) else $error("offset out of range");
  property p_sign; tx_freq_offset != 0 |-> tx_freq_offset[11] == !$past(radio_in.tx_bit); endproperty
  a_sign: assert property (p_sign) else $error("offset sign wrong");
  property p_msk_dir; msk_phase_eighths != 0 |-> msk_phase_up == !$past(radio_in.tx_bit); endproperty
  a_msk_dir: assert property (p_msk_dir) else $error("phase direction wrong");
  property p_msk_rng; msk_phase_up |-> msk_phase_eighths inside {[1:8]}; endproperty
  a_msk_rng: assert property (p_msk_rng) else $error("phase fraction wrong");
  property p_rx_only;
    rx_expected_dev != 0 |-> tx_freq_offset == 0 && msk_phase_eighths == 0 && rx_expected_dev >= 8;
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("rx deviation wrong");
  property p_rst;
    disable iff (1'b0) rst |=> tx_freq_offset == 0 && !rx_timeout && msk_phase_eighths == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  c_timeout: cover property (rx_timeout);
  c_msk: cover property (msk_phase_up);
  c_rx: cover property (rx_expected_dev != 0);
endmodule

bind rdt_top rdt_top_monitor i_rdt_top_monitor (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .rx_active(rx_active), .radio_in(radio_in),
  .tx_freq_offset(tx_freq_offset), .rx_expected_dev(rx_expected_dev),
  .msk_phase_eighths(msk_phase_eighths), .msk_phase_up(msk_phase_up),
  .rx_timeout(rx_timeout));

// ==== verif/test_radio_deviation_rx_timeout_cfg.sv ====
// Purpose: Self-checking bench of rdt_top.
// Assumes: APB with zero wait states, byte address four times the index.
// Notes:   Driver queues notes, a watcher compares them.
`timescale 1ns/100ps
`include "rdt_map.svh"
module test_radio_deviation_rx_timeout_cfg;
  logic                   ref_clk, rst, psel, penable, pwrite, rx_active, tick_64, look;
  logic                   pready, pslverr, msk_phase_up, rx_timeout;
  logic [31:0]            paddr, pwdata, prdata, x_q;
  logic signed [11:0]     tx_freq_offset;
  logic [10:0]            rx_expected_dev;
  logic [3:0]             msk_phase_eighths;
  rdt_pkg::rdt_radio_in_t radio_in;
  logic [64:0]            q[$];
  logic [64:0]            e;
  logic [32:0]            got;
  int                     n_errors, num_checks, n_to;
  logic [7:0] c_sm2 [8] = '{8'h05, 8'h0D, 8'h05, 8'h07, 8'h17, 8'h17, 8'h04, 8'h04};
  logic [7:0] c_ctl [8] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h06, 8'h06, 8'h04, 8'h04};
  logic [4:0] c_in [8] = '{5'h00, 5'h04, 5'h08, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [7:0] c_exp [8] = '{8'h23, 8'h0A, 8'h06, 8'h01, 8'h23, 8'h01, 8'h01, 8'h23};
  int         c_n [8] = '{2, 2, 2, 40, 8, 7, 3, 4};
  rdt_top i_rdt_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_active(rx_active), .tick_64(tick_64), .radio_in(radio_in),
    .tx_freq_offset(tx_freq_offset), .rx_expected_dev(rx_expected_dev),
    .msk_phase_eighths(msk_phase_eighths), .msk_phase_up(msk_phase_up),
    .rx_timeout(rx_timeout));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs();
    x_q ^= x_q << 13;
    x_q ^= x_q >> 17;
    x_q ^= x_q << 5;
    return x_q;
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rx_timeout === 1'b1) begin
      n_to++;
    end
    if ((psel && penable && pready && !pwrite) || look) begin
      e = q.pop_front();
      got = look ? {1'b0, n_to[3:0], tx_freq_offset, rx_expected_dev,
                    msk_phase_eighths, msk_phase_up}
                 : {pslverr, prdata};
      num_checks++;
      if ((got & {1'b1, e[63:32]}) !== ({e[64], e[31:0]} & {1'b1, e[63:32]})) begin
        n_errors++;
        $display("BAD %s exp %h got %h", look ? "outputs" : "prdata", {e[64], e[31:0]}, got);
      end
    end
  end
  task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {10'h000, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 0;
    penable <= 0;
    if (k >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [19:0] idx, input logic [31:0] x, input logic [31:0] m,
                    input logic er);
    q.push_back({er, m, x});
    apb(0, idx, 32'h0000_0000);
  endtask
  task automatic look_at(input logic [31:0] x, input logic [31:0] m);
    repeat (3) @(posedge ref_clk);
    q.push_back({1'b0, m, x});
    look <= 1;
    @(posedge ref_clk);
    look <= 0;
  endtask
  task automatic pulse(input int n, input logic s);
    repeat (n) begin
      @(posedge ref_clk);
      if (s) radio_in.sym_tick <= 1;
      else tick_64 <= 1;
      @(posedge ref_clk);
      radio_in.sym_tick <= 0;
      tick_64 <= 0;
    end
  endtask
  initial begin
    logic [31:0] r;
    logic [10:0] d;
    logic [11:0] o;
    logic [1:0]  md;
    logic        tx;
    logic [3:0]  n_exp;
    n_exp = 4'h0;
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; look = 0;
    rx_active = 0; tick_64 = 0; radio_in = '0; x_q = 32'h0000_000B;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    rd(`RDT_DEV_IDX, 32'h0000_0047, '1, 0);
    rd(`RDT_SM2_IDX, 32'h0000_0007, '1, 0);
    apb(1, `RDT_SM2_IDX, 32'hFFFF_FFFF);
    rd(`RDT_SM2_IDX, 32'h0000_001F, '1, 0);
    rd(20'h0_DF30, 32'h0000_0000, '1, 1);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      md = i[1:0];
      tx = i[2];
      d = (11'd8 + r[2:0]) << r[6:4];
      o = (!tx || md[1]) ? 12'h000 : (r[11] ? {1'b0, d} : -{1'b0, d});
      apb(1, `RDT_DEV_IDX, {24'h00_0000, r[7:0]});
      apb(1, `RDT_CTRL_IDX, {28'h000_0000, tx, !tx, md});
      radio_in <= {4'h0, r[11]};
      look_at({4'h0, o, (!tx && !md[1]) ? d : 11'h000,
               (tx && md == 2'b11) ? {1'b0, r[2:0]} + 4'h1 : 4'h0, tx && md == 2'b11 && !r[11]},
              32'hFFFF_FFFF);
    end
    apb(1, `RDT_EV0_IDX, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      apb(1, `RDT_SM2_IDX, {24'h00_0000, c_sm2[i]});
      apb(1, `RDT_CTRL_IDX, {24'h00_0000, c_ctl[i]});
      radio_in <= c_in[i];
      @(posedge ref_clk);
      rx_active <= 1;
      repeat (2) @(posedge ref_clk);
      pulse(c_n[i], c_ctl[i][1]);
      repeat (4) @(posedge ref_clk);
      rd(`RDT_STAT_IDX, {24'h00_0000, c_exp[i]}, '1, 0);
      rx_active <= 0;
      radio_in <= '0;
      n_exp = n_exp + {3'h0, c_exp[i][5]};
      look_at({n_exp, 28'h000_0000}, 32'hF000_0000);
    end
    repeat (4) @(posedge ref_clk);
    complete_run();
  end
endmodule
